/* File: aqch_pkg.sv */
// constants and types for the administration queue command handler
package aqch_pkg;

	// data path and length fields
	localparam int            AQCH_W          = 64;
	localparam int            AQCH_WLEN_W     = 8;
	localparam int            AQCH_BYTES_W    = 11;
	localparam logic [3:0]    AQCH_WORD_BYTES = 4'h8;

	// readable word positions
	localparam logic [2:0]    AQCH_WI_HDR     = 3'h0;
	localparam logic [2:0]    AQCH_WI_MEMBER  = 3'h2;
	localparam logic [2:0]    AQCH_WI_DATA    = 3'h3;
	localparam logic [2:0]    AQCH_WI_SAT     = 3'h4;

	// field positions inside the header and status words
	localparam int            AQCH_OPC_LSB    = 0;
	localparam int            AQCH_GRP_LSB    = 16;
	localparam int            AQCH_ST_LSB     = 0;
	localparam int            AQCH_QL_LSB     = 16;
	localparam int            AQCH_F_W        = 16;

	// result lengths in words
	localparam logic [1:0]    AQCH_RES_HDR    = 2'h1;
	localparam logic [1:0]    AQCH_RES_FULL   = 2'h2;

	// opcodes and group type
	localparam logic [15:0]   AQCH_OPC_QUERY  = 16'h0000;
	localparam logic [15:0]   AQCH_OPC_USE    = 16'h0001;
	localparam logic [15:0]   AQCH_OPC_LIMIT  = 16'h0040;
	localparam logic [15:0]   AQCH_GRP_SRIOV  = 16'h0001;

	// list of usable opcodes after reset: query and use
	localparam logic [63:0]   AQCH_LIST_RST   = 64'h0000_0000_0000_0003;

	// status codes
	localparam logic [15:0]   AQCH_ST_OK      = 16'h0000;
	localparam logic [15:0]   AQCH_ST_EAGAIN  = 16'h000b;
	localparam logic [15:0]   AQCH_ST_ENOMEM  = 16'h000c;
	localparam logic [15:0]   AQCH_ST_EINVAL  = 16'h0016;

	// status qualifiers
	localparam logic [15:0]   AQCH_Q_CMD      = 16'h0000;
	localparam logic [15:0]   AQCH_Q_OPCODE   = 16'h0001;
	localparam logic [15:0]   AQCH_Q_FIELD    = 16'h0002;
	localparam logic [15:0]   AQCH_Q_GROUP    = 16'h0003;
	localparam logic [15:0]   AQCH_Q_MEMBER   = 16'h0004;

	// command sequencer
	typedef enum logic [2:0] {
		AQCH_S_RECV = 3'b000,
		AQCH_S_EVAL = 3'b001,
		AQCH_S_EXEC = 3'b010,
		AQCH_S_RESP = 3'b011,
		AQCH_S_CPL  = 3'b100
	} aqch_state_t;

endpackage

/* File: aqch_top.sv */
// administration queue command handler: intake, checks, list state, result writer
`timescale 1ns/10ps
`default_nettype none
module aqch_top
	import aqch_pkg::*;
(
	input  wire logic                    clk,            // 40 MHz clock
	input  wire logic                    arst_n,         // async reset, active low
	input  wire logic                    cmd_valid,      // readable word offered
	output logic                         cmd_ready,      // readable word taken
	input  wire logic [AQCH_W-1:0]       cmd_data,       // readable word
	input  wire logic                    cmd_last,       // last readable word
	input  wire logic                    cmd_qid,        // queue of the command
	input  wire logic [AQCH_WLEN_W-1:0]  cmd_wr_words,   // writable part, 64-bit words
	output logic                         rsp_valid,      // writable word offered
	input  wire logic                    rsp_ready,      // writable word accepted
	output logic [AQCH_W-1:0]            rsp_data,       // writable word
	output logic                         rsp_qid,        // queue of the answer
	output logic                         cpl_valid,      // completion offered
	input  wire logic                    cpl_ready,      // completion accepted
	output logic                         cpl_qid,        // queue to mark used on
	output logic [AQCH_BYTES_W-1:0]      cpl_used_bytes, // used length in bytes
	output logic                         exec_req,       // pulse: run a command
	output logic [15:0]                  exec_opcode,    // opcode to run
	output logic [AQCH_W-1:0]            exec_member,    // member id
	output logic [AQCH_W-1:0]            exec_data,      // first specific data word
	input  wire logic                    exec_done,      // pulse: command finished
	input  wire logic [15:0]             exec_status,    // its status
	input  wire logic [15:0]             exec_qual,      // its qualifier
	input  wire logic [AQCH_W-1:0]       exec_result,    // its first result word
	input  wire logic                    vf_enable,      // vf enable bit
	input  wire logic [15:0]             num_vfs,        // vf count
	input  wire logic [AQCH_W-1:0]       supported_ops,  // opcodes the device offers
	output logic [AQCH_W-1:0]            used_ops        // opcodes the driver chose
);

	////////////////////////////////////////////////////////////////////////////////
	// state and captured fields

	aqch_state_t              state;
	logic [2:0]               rd_idx;
	logic [15:0]              opc;
	logic [15:0]              grp;
	logic [AQCH_W-1:0]        member;
	logic [AQCH_W-1:0]        data0;
	logic                     qid;
	logic [AQCH_WLEN_W-1:0]   wr_words;
	logic [15:0]              st;
	logic [15:0]              ql;
	logic [AQCH_W-1:0]        res_word;
	logic [1:0]               res_words;
	logic [AQCH_WLEN_W-1:0]   rsp_cnt;
	logic [AQCH_WLEN_W-1:0]   rsp_total;

	// opcode lookup in a 64-entry bitmap, out of range reads as absent
	function automatic logic aqch_op_in(input logic [AQCH_W-1:0] map, input logic [15:0] op);
		aqch_op_in = (op < AQCH_OPC_LIMIT) && map[op[5:0]];
	endfunction

	// check order: group, then opcode, then member, then list-use field
	logic is_list;
	logic grp_bad;
	logic opc_bad;
	logic mem_bad;
	logic fld_bad;
	assign is_list = (opc == AQCH_OPC_QUERY) || (opc == AQCH_OPC_USE);
	assign grp_bad = (grp != AQCH_GRP_SRIOV) || !vf_enable;
	assign opc_bad = !aqch_op_in(used_ops, opc);
	assign mem_bad = !is_list && ((member == '0) || (member > {48'h0000_0000_0000, num_vfs}));
	assign fld_bad = (opc == AQCH_OPC_USE) && |(data0 & ~supported_ops);

	// written words: shorter of supplied and expected, so always whole words
	assign rsp_total = (wr_words < AQCH_WLEN_W'(res_words)) ? wr_words
		: AQCH_WLEN_W'(res_words);

	////////////////////////////////////////////////////////////////////////////////
	// sequencer: one command at a time, so a queue's order is kept and
	// both queues share one in-order stream, which the relaxed order permits

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= AQCH_S_RECV;
		end else begin
			case (state)
				AQCH_S_RECV: begin
					if (cmd_valid && cmd_last)
						state <= AQCH_S_EVAL;
				end
				AQCH_S_EVAL: begin
					if (grp_bad || opc_bad || mem_bad || is_list)
						state <= AQCH_S_RESP;
					else
						state <= AQCH_S_EXEC;
				end
				AQCH_S_EXEC: begin
					if (exec_done)
						state <= AQCH_S_RESP;
				end
				AQCH_S_RESP: begin
					if (!rsp_valid)
						state <= AQCH_S_CPL;
				end
				AQCH_S_CPL: begin
					if (cpl_ready)
						state <= AQCH_S_RECV;
				end
				default: begin
					state <= AQCH_S_RECV;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// intake: words past the known layout are dropped, fields never sent stay zero

	assign cmd_ready = (state == AQCH_S_RECV);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_idx   <= AQCH_WI_HDR;
			opc      <= '0;
			grp      <= '0;
			member   <= '0;
			data0    <= '0;
			qid      <= 1'b0;
			wr_words <= '0;
		end else if (state == AQCH_S_CPL && cpl_ready) begin
			rd_idx   <= AQCH_WI_HDR;
			opc      <= '0;
			grp      <= '0;
			member   <= '0;
			data0    <= '0;
		end else if (cmd_valid && cmd_ready) begin
			if (rd_idx != AQCH_WI_SAT)
				rd_idx <= rd_idx + 3'h1;
			if (rd_idx == AQCH_WI_HDR) begin
				opc      <= cmd_data[AQCH_OPC_LSB +: AQCH_F_W];
				grp      <= cmd_data[AQCH_GRP_LSB +: AQCH_F_W];
				qid      <= cmd_qid;
				wr_words <= cmd_wr_words;
			end
			if (rd_idx == AQCH_WI_MEMBER)
				member <= cmd_data;
			if (rd_idx == AQCH_WI_DATA)
				data0 <= cmd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// verdict; lengths never enter it, so odd sizes cannot fail a command
	// next values are shared with the result writer, which must load the fresh
	// status on the same edge that opens the answer, not the previous command's

	logic [15:0]              next_st;
	logic [15:0]              next_ql;
	logic [AQCH_W-1:0]        next_res_word;
	logic [1:0]               next_res_words;

	always_comb begin
		next_st        = st;
		next_ql        = ql;
		next_res_word  = res_word;
		next_res_words = res_words;
		if (state == AQCH_S_EVAL) begin
			next_res_word  = '0;
			next_res_words = AQCH_RES_HDR;
			next_st        = AQCH_ST_EINVAL;
			if (grp_bad) begin
				next_ql = AQCH_Q_GROUP;
			end else if (opc_bad) begin
				next_ql = AQCH_Q_OPCODE;
			end else if (mem_bad) begin
				next_ql = AQCH_Q_MEMBER;
			end else if (fld_bad) begin
				next_ql = AQCH_Q_FIELD;
			end else begin
				next_st = AQCH_ST_OK;
				next_ql = AQCH_Q_CMD;
				if (opc == AQCH_OPC_QUERY) begin
					next_res_word  = supported_ops;
					next_res_words = AQCH_RES_FULL;
				end
			end
		end else if (state == AQCH_S_EXEC && exec_done) begin
			// try-again/out-of-memory results are passed on unchanged; the
			// executor commits nothing for them, this block holds no state for it
			next_st        = exec_status;
			next_ql        = exec_qual;
			next_res_word  = exec_result;
			next_res_words = AQCH_RES_FULL;
		end
	end

	// verdict registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st        <= AQCH_ST_OK;
			ql        <= AQCH_Q_CMD;
			res_word  <= '0;
			res_words <= AQCH_RES_HDR;
		end else begin
			st        <= next_st;
			ql        <= next_ql;
			res_word  <= next_res_word;
			res_words <= next_res_words;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// used-opcode list, replaced only by a list-use that passed every check

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			used_ops <= AQCH_LIST_RST;
		end else if (state == AQCH_S_EVAL && opc == AQCH_OPC_USE
				&& !grp_bad && !opc_bad && !fld_bad) begin
			used_ops <= data0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// executor hand-off, a single pulse when a non-list command passes the checks

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			exec_req    <= 1'b0;
			exec_opcode <= '0;
			exec_member <= '0;
			exec_data   <= '0;
		end else begin
			exec_req <= (state == AQCH_S_EVAL) && !(grp_bad || opc_bad || mem_bad || is_list);
			if (state == AQCH_S_EVAL) begin
				exec_opcode <= opc;
				exec_member <= member;
				exec_data   <= data0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// result writer: status word first, then the result word, zero when empty

	assign rsp_valid = (state == AQCH_S_RESP) && (rsp_cnt < rsp_total);
	assign rsp_qid   = qid;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_cnt  <= '0;
			rsp_data <= '0;
		end else if (state != AQCH_S_RESP) begin
			rsp_cnt  <= '0;
			rsp_data <= '0;
			rsp_data[AQCH_ST_LSB +: AQCH_F_W] <= next_st;
			rsp_data[AQCH_QL_LSB +: AQCH_F_W] <= next_ql;
		end else if (rsp_valid && rsp_ready) begin
			rsp_cnt  <= rsp_cnt + AQCH_WLEN_W'(1);
			rsp_data <= res_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// completion: used length counts only words really written

	assign cpl_valid = (state == AQCH_S_CPL);
	assign cpl_qid   = qid;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cpl_used_bytes <= '0;
		end else if (state == AQCH_S_RESP && !rsp_valid) begin
			cpl_used_bytes <= AQCH_BYTES_W'(rsp_cnt) * AQCH_BYTES_W'(AQCH_WORD_BYTES);
		end
	end

endmodule
`default_nettype wire

/* File: aqch_checker.sv */
// port timing checker of the command handler
`timescale 1ns/10ps
`default_nettype none
module aqch_checker
	import aqch_pkg::*;
(
	input wire logic                    clk,            // clock
	input wire logic                    arst_n,         // reset, low
	input wire logic                    cmd_valid,      // word offered
	input wire logic                    cmd_ready,      // word taken
	input wire logic                    cmd_last,       // last word
	input wire logic                    rsp_valid,      // answer word
	input wire logic                    rsp_ready,      // answer taken
	input wire logic [AQCH_W-1:0]       rsp_data,       // answer data
	input wire logic                    rsp_qid,        // answer queue
	input wire logic                    cpl_valid,      // completion
	input wire logic                    cpl_ready,      // completion taken
	input wire logic                    cpl_qid,        // used queue
	input wire logic [AQCH_BYTES_W-1:0] cpl_used_bytes, // used length
	input wire logic                    exec_req        // run pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic q_rsp;
	////////////////////////////////////////////////////////////
	// queue of the last accepted answer word
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			q_rsp <= 1'b0;
		else if (rsp_valid && rsp_ready)
			q_rsp <= rsp_qid;
	end
	////////////////////////////////////////////////////////////
	// steps of one command: last word in, then intake shut
	sequence s_last;
		cmd_valid && cmd_ready && cmd_last;
	endsequence
	sequence s_closed;
		!cmd_ready [*2];
	endsequence
	a_intake_stop: assert property (s_last |=> s_closed)
		else $error("intake reopened too soon");
	a_run_pulse: assert property (exec_req |=> !exec_req)
		else $error("run request longer than one cycle");
	a_answer_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
		else $error("answer word changed while stalled");
	a_cpl_hold: assert property (cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl_used_bytes))
		else $error("completion changed while stalled");
	a_used_words: assert property (cpl_valid |-> cpl_used_bytes[2:0] == 3'h0)
		else $error("used length not whole words");
	a_used_bound: assert property (cpl_valid |-> cpl_used_bytes <= 11'h010)
		else $error("used length beyond result structure");
	a_same_queue: assert property (cpl_valid |-> cpl_qid == q_rsp)
		else $error("completion on another queue");
	a_ready_after: assert property (cpl_valid && cpl_ready |=> cmd_ready)
		else $error("intake not reopened after completion");
	a_idle_quiet: assert property (cmd_ready |-> !rsp_valid && !cpl_valid)
		else $error("answer while taking commands");
endmodule
bind aqch_top aqch_checker aqch_checker_i (.*);
`default_nettype wire

/* File: aqch_exec_model.sv */
// behavioural command executor beside the handler
`timescale 1ns/10ps
`default_nettype none
module aqch_exec_model
	import aqch_pkg::*;
(
	input wire logic        clk,         // clock
	input wire logic        arst_n,      // reset, low
	input wire logic        exec_req,    // run pulse
	input wire logic [15:0] exec_opcode, // opcode
	input wire logic [63:0] exec_member, // member id
	input wire logic [3:0]  lat,         // extra wait cycles
	input wire logic [15:0] st_cfg,      // status to give
	output logic            exec_done,   // done pulse
	output logic [15:0]     exec_status, // status
	output logic [15:0]     exec_qual,   // qualifier
	output logic [63:0]     exec_result  // result word
);
	logic [3:0] cnt;
	logic       busy;
	logic [63:0] res;
	////////////////////////////////////////////////////////////
	// wait lat cycles, then one done pulse
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			exec_done <= 1'b0;
		end else begin
			exec_done <= 1'b0;
			if (exec_req) begin
				busy <= 1'b1;
				cnt <= lat;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
				exec_done <= 1'b1;
			end else if (busy)
				cnt <= cnt - 4'h1;
		end
	end
	// answers inverted outside the pulse so stale values never match
	assign res = {exec_member[47:0], exec_opcode};
	assign exec_status = exec_done ? st_cfg : ~st_cfg;
	assign exec_qual = exec_done ? AQCH_Q_CMD : ~AQCH_Q_CMD;
	assign exec_result = exec_done ? res : ~res;
endmodule
`default_nettype wire

/* File: aqch_top_tb.sv */
// self-checking bench of the command handler
`timescale 1ns/10ps
`default_nettype none
module aqch_top_tb;
	import aqch_pkg::*;
	logic clk = 0, arst_n = 0, cmd_valid = 0, cmd_last = 0, cmd_qid = 0;
	logic rsp_ready = 0, cpl_ready = 0, vf_enable = 1;
	logic [63:0] cmd_data = 0, supported_ops = 64'h0000_0000_0000_0007;
	logic [7:0] cmd_wr_words = 0;
	logic [15:0] num_vfs = 16'h0004, st_cfg = 0;
	logic [3:0] lat = 0;
	logic cmd_ready, rsp_valid, rsp_qid, cpl_valid, cpl_qid, exec_req, exec_done;
	logic [63:0] rsp_data, exec_member, exec_data, exec_result, used_ops;
	logic [10:0] cpl_used_bytes;
	logic [15:0] exec_opcode, exec_status, exec_qual;
	int fail_count = 0, n_checks = 0;
	logic [15:0] st_list[3] = '{AQCH_ST_EAGAIN, AQCH_ST_ENOMEM, AQCH_ST_OK};
	aqch_top aqch_top_i (
		.clk            (clk),
		.arst_n         (arst_n),
		.cmd_valid      (cmd_valid),
		.cmd_ready      (cmd_ready),
		.cmd_data       (cmd_data),
		.cmd_last       (cmd_last),
		.cmd_qid        (cmd_qid),
		.cmd_wr_words   (cmd_wr_words),
		.rsp_valid      (rsp_valid),
		.rsp_ready      (rsp_ready),
		.rsp_data       (rsp_data),
		.rsp_qid        (rsp_qid),
		.cpl_valid      (cpl_valid),
		.cpl_ready      (cpl_ready),
		.cpl_qid        (cpl_qid),
		.cpl_used_bytes (cpl_used_bytes),
		.exec_req       (exec_req),
		.exec_opcode    (exec_opcode),
		.exec_member    (exec_member),
		.exec_data      (exec_data),
		.exec_done      (exec_done),
		.exec_status    (exec_status),
		.exec_qual      (exec_qual),
		.exec_result    (exec_result),
		.vf_enable      (vf_enable),
		.num_vfs        (num_vfs),
		.supported_ops  (supported_ops),
		.used_ops       (used_ops)
	);
	aqch_exec_model aqch_exec_model_i (
		.clk         (clk),
		.arst_n      (arst_n),
		.exec_req    (exec_req),
		.exec_opcode (exec_opcode),
		.exec_member (exec_member),
		.lat         (lat),
		.st_cfg      (st_cfg),
		.exec_done   (exec_done),
		.exec_status (exec_status),
		.exec_qual   (exec_qual),
		.exec_result (exec_result)
	);
	always #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [63:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic summarize();
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	function automatic logic [31:0] h(input logic [15:0] op);
		return {AQCH_GRP_SRIOV, op};
	endfunction
	// one command: readable words in, answer words and completion out
	task automatic cmd(input logic [31:0] hdr, input logic [63:0] mem, dat,
			input int nrd, nwr, input logic q, input logic [15:0] est, eql,
			input logic [63:0] eres, input int ew);
		logic [63:0] w[4] = '{{32'h0, hdr}, 64'h0, mem, dat};
		logic [63:0] got[$];
		logic done = 0;
		int nexp = (nwr < ew) ? nwr : ew;
		for (int i = 0; i < nrd; i++) begin
			cmd_valid <= 1'b1;
			cmd_data <= w[i];
			cmd_last <= (i == nrd - 1);
			cmd_qid <= q;
			cmd_wr_words <= nwr[7:0];
			do @(posedge clk); while (cmd_ready !== 1'b1);
		end
		cmd_valid <= 1'b0;
		// accept only every other cycle so the handler must hold its answers
		for (int k = 0; k < 60 && !done; k++) begin
			rsp_ready <= k[0];
			cpl_ready <= k[0];
			@(posedge clk);
			if (rsp_valid === 1'b1 && rsp_ready) begin
				got.push_back(rsp_data);
				chk("rsp_queue", {63'h0, rsp_qid}, {63'h0, q});
			end
			if (cpl_valid === 1'b1 && cpl_ready) begin
				done = 1;
				chk("used", {53'h0, cpl_used_bytes}, 64'(nexp * 8));
				chk("queue", {63'h0, cpl_qid}, {63'h0, q});
			end
		end
		chk("done", {63'h0, done}, 64'h1);
		chk("words", 64'(got.size()), 64'(nexp));
		chk("member", exec_member, (nrd > 2) ? mem : 64'h0);
		chk("spec_data", exec_data, (nrd > 3) ? dat : 64'h0);
		if (got.size() > 0)
			chk("status", got[0], {32'h0, eql, est});
		if (got.size() > 1)
			chk("result", got[1], eres);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		chk("ops_rst", used_ops, AQCH_LIST_RST);
		arst_n <= 1'b1;
		cmd(h(16'h0002), 1, 0, 4, 2, 0, AQCH_ST_EINVAL, AQCH_Q_OPCODE, 0, 1);
		cmd(h(AQCH_OPC_QUERY), 0, 0, 1, 4, 0, AQCH_ST_OK, AQCH_Q_CMD, supported_ops, 2);
		cmd(h(AQCH_OPC_USE), 0, 64'h8, 4, 2, 0, AQCH_ST_EINVAL, AQCH_Q_FIELD, 0, 1);
		chk("ops_kept", used_ops, AQCH_LIST_RST);
		cmd(h(AQCH_OPC_USE), 0, 64'h7, 4, 1, 1, AQCH_ST_OK, AQCH_Q_CMD, 0, 1);
		chk("ops_set", used_ops, 64'h7);
		cmd(h(16'h0002), 0, 0, 4, 2, 1, AQCH_ST_EINVAL, AQCH_Q_MEMBER, 0, 1);
		cmd(h(16'h0002), 5, 0, 4, 2, 1, AQCH_ST_EINVAL, AQCH_Q_MEMBER, 0, 1);
		cmd(h(16'h0002), 4, 0, 3, 1, 1, AQCH_ST_OK, AQCH_Q_CMD, 0, 2);
		// retry codes first, then the resubmitted command succeeds
		foreach (st_list[j]) begin
			st_cfg <= st_list[j];
			lat <= 4'h5;
			cmd(h(16'h0002), 1, 0, 4, 3, 0, st_list[j], AQCH_Q_CMD, 64'h0001_0002, 2);
		end
		cmd({16'h0002, 16'h0002}, 1, 0, 4, 1, 0, AQCH_ST_EINVAL, AQCH_Q_GROUP, 0, 1);
		vf_enable <= 1'b0;
		cmd(h(16'h0002), 1, 0, 4, 1, 0, AQCH_ST_EINVAL, AQCH_Q_GROUP, 0, 1);
		vf_enable <= 1'b1;
		cmd(h(AQCH_OPC_USE), 0, 64'h4, 4, 1, 0, AQCH_ST_OK, AQCH_Q_CMD, 0, 1);
		cmd(h(AQCH_OPC_QUERY), 0, 0, 4, 2, 0, AQCH_ST_EINVAL, AQCH_Q_OPCODE, 0, 1);
		cmd(h(16'h0002), 1, 0, 4, 1, 0, AQCH_ST_OK, AQCH_Q_CMD, 0, 2);
		summarize();
	end
	// cut a hang short well past the expected run length
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule
`default_nettype wire
